// *** spi_pin_roles_mode_fault_bench.sv ***
// self-checking bench for the spi pin-role core with the peer model.
// assumes default word length and half period of the core.
`timescale 1ns/1ns
// ----
// bench
// ----
module spi_pin_roles_mode_fault_bench;
    logic clk = 1'h0;
    logic rst_n = 1'h1;
    logic mm = 1'h1;
    logic pol = 1'h0;
    logic pha = 1'h0;
    logic od = 1'h0;
    logic start = 1'h0;
    logic tx_load = 1'h0;
    logic [7:0] tx_data = 8'h00;
    logic fclr = 1'h0;
    logic ps_sel_n = 1'h1;
    logic [7:0] pword = 8'h00;
    logic busy, done, mfault, d_sclk, d_sclk_oe, d_mosi, d_mosi_oe, d_miso, d_miso_oe;
    logic [7:0] rx_data;
    logic p_sclk, p_sclk_oe, p_mosi, p_mosi_oe, p_miso, p_miso_oe, dsel_n;
    wire sclk_w = d_sclk_oe ? d_sclk : p_sclk_oe ? p_sclk : 1'h1;
    wire mosi_w = d_mosi_oe ? d_mosi : p_mosi_oe ? p_mosi : 1'h1;
    wire miso_w = d_miso_oe ? d_miso : p_miso_oe ? p_miso : 1'h1;
    int errors = 0;
    int check_count = 0;
    int dcnt = 0;
    always #2 clk = !clk;
    always @(posedge clk)
        if (done === 1'h1)
            dcnt++;
    spipr_core #(.WORD_BITS(8), .HALF_CYCLES(8)) u_spipr_core (.core_clk_i(clk),
        .rst_n_i(rst_n), .master_mode_i(mm), .clk_polarity_i(pol), .clk_phase_i(pha),
        .miso_open_drain_enable_i(od), .start_i(start), .tx_load_i(tx_load),
        .tx_data_i(tx_data), .fault_clear_i(fclr), .busy_o(busy), .done_o(done),
        .rx_data_o(rx_data), .mode_fault_o(mfault), .slave_select_n_i(dsel_n),
        .serial_shift_clock_i(sclk_w), .serial_shift_clock_o(d_sclk),
        .serial_shift_clock_oe_o(d_sclk_oe), .mosi_i(mosi_w), .mosi_o(d_mosi),
        .mosi_oe_o(d_mosi_oe), .miso_i(miso_w), .miso_o(d_miso), .miso_oe_o(d_miso_oe));
    spipr_peer u_spipr_peer (.pol_i(pol), .pha_i(pha), .sel_n_i(ps_sel_n), .word_i(pword),
        .sclk_i(sclk_w), .mosi_i(mosi_w), .miso_i(miso_w), .sclk_o(p_sclk),
        .sclk_oe_o(p_sclk_oe), .mosi_o(p_mosi), .mosi_oe_o(p_mosi_oe), .miso_o(p_miso),
        .miso_oe_o(p_miso_oe), .dsel_n_o(dsel_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    always @(negedge clk)
        if (od && d_miso_oe === 1'h1)
            check(d_miso, 1'h0);
    task automatic results;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic master_word(input logic p, input logic h, input logic [7:0] tx,
        input logic [7:0] pw);
        int n;
        int d0;
        pol = p;
        pha = h;
        pword = pw;
        tx_data = tx;
        repeat (2) @(negedge clk);
        ps_sel_n = 1'h0;
        repeat (2) @(negedge clk);
        d0 = dcnt;
        start = 1'h1;
        @(negedge clk);
        start = 1'h0;
        check(d_mosi_oe, 1'h1);
        check(d_miso_oe, 1'h0);
        n = 0;
        while (dcnt == d0 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        check(dcnt - d0, 1);
        check(rx_data, pw);
        check(u_spipr_peer.rx, tx);
        check(u_spipr_peer.edges, 16);
        check(d_sclk, p);
        ps_sel_n = 1'h1;
    endtask : master_word
    task automatic fault_case;
        int n;
        start = 1'h1;
        @(negedge clk);
        start = 1'h0;
        repeat (20) @(negedge clk);
        n = dcnt;
        u_spipr_peer.grab(1'h0);
        repeat (10) @(negedge clk);
        check(mfault, 1'h1);
        check(busy, 1'h0);
        check(d_sclk_oe, 1'h0);
        u_spipr_peer.grab(1'h1);
        repeat (10) @(negedge clk);
        check(mfault, 1'h1);
        check(dcnt, n);
        fclr = 1'h1;
        @(negedge clk);
        fclr = 1'h0;
        @(negedge clk);
        check(mfault, 1'h0);
    endtask : fault_case
    task automatic slave_word(input logic p, input logic h, input logic [7:0] tx,
        input logic [7:0] pw, input logic en, input logic o);
        int d0;
        pol = p;
        pha = h;
        od = o;
        tx_data = tx;
        tx_load = 1'h1;
        @(negedge clk);
        tx_load = 1'h0;
        @(negedge clk);
        d0 = dcnt;
        fork
            u_spipr_peer.xfer(pw, en);
            begin
                #100;
                if (!o)
                    check(d_miso_oe, en);
                check(d_mosi_oe, 1'h0);
            end
        join
        repeat (12) @(negedge clk);
        check(dcnt - d0, en);
        if (en)
        begin
            check(rx_data, pw);
            check(u_spipr_peer.rx, tx);
        end
        od = 1'h0;
    endtask : slave_word
    initial
    begin
        #100000;
        errors++;
        results();
    end
    initial
    begin
        // a real reset edge, and one select pulse, so the pin-clock flops
        // with edge-triggered resets start from known values
        @(negedge clk);
        rst_n = 1'h0;
        mm = 1'h0;
        u_spipr_peer.grab(1'h0);
        @(negedge clk);
        u_spipr_peer.grab(1'h1);
        @(negedge clk);
        mm = 1'h1;
        @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        check(mfault, 1'h0);
        check(busy, 1'h0);
        repeat (8) @(negedge clk);
        for (int m = 0; m < 4; m++)
            master_word(m[1], m[0], 8'h96 ^ m[7:0], 8'h5B + m[7:0]);
        fault_case();
        mm = 1'h0;
        for (int m = 0; m < 4; m++)
            slave_word(m[1], m[0], 8'hC4 ^ m[7:0], 8'h39 + m[7:0], 1'h1, 1'h0);
        slave_word(1'h0, 1'h0, 8'h81, 8'h7E, 1'h0, 1'h0);
        slave_word(1'h0, 1'h1, 8'h5A, 8'hE1, 1'h1, 1'h1);
        results();
    end
endmodule : spi_pin_roles_mode_fault_bench

// *** spipr_core.sv ***
// spi port pin roles: data line directions, open-drain miso, slave select
// as chip enable or multimaster error, master shift engine, slave shifter.
// assumes config ports are static during a frame; slave logic runs on the pin clock.
//
// How it works
// - as slave, act on transfers only while slave select is low
// - as master, slave select pulled low flags a multimaster error
// - as master, drive mosi with transmitted data
// - as slave, mosi is an input shifted into the receiver
// - as master, miso is an input shifted into the receiver
// - as slave, drive miso with transmitted data
// - open-drain enable: miso pulls low only, releases for high
// - only master drives the shift clock, once per bit, during transfers
// - slave ignores the shift clock while its select is high
// - launch on one edge, sample on the other; polarity and phase selectable

`timescale 1ns/1ns

module spipr_core
#(
    parameter int WORD_BITS = spipr_pkg::WORD_BITS,
    parameter int HALF_CYCLES = spipr_pkg::SCLK_HALF_CYCLES
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic master_mode_i,
    input wire logic clk_polarity_i,
    input wire logic clk_phase_i,
    input wire logic miso_open_drain_enable_i,
    input wire logic start_i,
    input wire logic tx_load_i,
    input wire logic [WORD_BITS-1:0] tx_data_i,
    input wire logic fault_clear_i,
    output logic busy_o,
    output logic done_o,
    output logic [WORD_BITS-1:0] rx_data_o,
    output logic mode_fault_o,
    input wire logic slave_select_n_i,
    input wire logic serial_shift_clock_i,
    output logic serial_shift_clock_o,
    output logic serial_shift_clock_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o
);
    localparam int CW = $clog2(WORD_BITS);
    localparam int EW = $clog2(2 * WORD_BITS);
    localparam int HW = $clog2(HALF_CYCLES);
    localparam logic [EW-1:0] LAST_EDGE = EW'(2 * WORD_BITS - 1);
    localparam logic [HW-1:0] LAST_HALF = HW'(HALF_CYCLES - 1);
    localparam logic [CW-1:0] LAST_BIT = CW'(WORD_BITS - 1);

    function automatic logic [WORD_BITS-1:0] shl(input logic [WORD_BITS-1:0] v,
                                                 input logic b);
        shl = {v[WORD_BITS-2:0], b};
    endfunction : shl

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic sel_n_s;
    logic miso_s;
    logic word_tgl_s;
    logic word_tgl;

    spipr_sync #(.INIT(spipr_pkg::IDLE_HIGH)) u_sel_sync
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(slave_select_n_i),
        .sync_o(sel_n_s)
    );

    spipr_sync #(.INIT(spipr_pkg::IDLE_HIGH)) u_miso_sync
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(miso_i),
        .sync_o(miso_s)
    );

    spipr_sync #(.INIT(1'h0)) u_tgl_sync
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(word_tgl),
        .sync_o(word_tgl_s)
    );

    // ------------------------------------------------------------------
    // multimaster error
    // ------------------------------------------------------------------
    logic fault_set;
    assign fault_set = master_mode_i && (sel_n_s == spipr_pkg::SEL_ACTIVE);

    // set wins over clear so a fresh error is never lost
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            mode_fault_o <= 1'h0;
        else if (fault_set)
            mode_fault_o <= 1'h1;
        else if (fault_clear_i)
            mode_fault_o <= 1'h0;
    end

    // ------------------------------------------------------------------
    // master shift engine
    // ------------------------------------------------------------------
    spipr_pkg::spipr_mst_e state;
    logic [HW-1:0] half_cnt;
    logic [EW-1:0] edge_cnt;
    logic [WORD_BITS-1:0] m_tx;
    logic [WORD_BITS-1:0] m_rx;
    logic half_end;
    logic samp_edge;
    logic abort;

    assign half_end = (half_cnt == LAST_HALF);
    assign samp_edge = (edge_cnt[0] == clk_phase_i);
    assign abort = fault_set || mode_fault_o || !master_mode_i;
    assign busy_o = (state == spipr_pkg::MS_SHIFT);

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            state <= spipr_pkg::MS_IDLE;
            half_cnt <= '0;
            edge_cnt <= '0;
            m_tx <= '0;
            m_rx <= '0;
            serial_shift_clock_o <= 1'h0;
        end
        else
        begin
            case (state)
                spipr_pkg::MS_IDLE:
                begin
                    serial_shift_clock_o <= clk_polarity_i;
                    half_cnt <= '0;
                    edge_cnt <= '0;
                    if (start_i && !abort)
                    begin
                        m_tx <= tx_data_i;
                        state <= spipr_pkg::MS_SHIFT;
                    end
                end
                spipr_pkg::MS_SHIFT:
                begin
                    // an error ends the word at once; clock parks idle
                    if (abort)
                    begin
                        state <= spipr_pkg::MS_IDLE;
                        serial_shift_clock_o <= clk_polarity_i;
                    end
                    else if (half_end)
                    begin
                        half_cnt <= '0;
                        serial_shift_clock_o <= ~serial_shift_clock_o;
                        edge_cnt <= edge_cnt + 1'b1;
                        if (samp_edge)
                        begin
                            m_rx <= shl(m_rx, miso_s);
                        end
                        else if (!(clk_phase_i && edge_cnt == '0))
                        begin
                            m_tx <= shl(m_tx, 1'h0);
                        end
                        if (edge_cnt == LAST_EDGE)
                            state <= spipr_pkg::MS_IDLE;
                    end
                    else
                    begin
                        half_cnt <= half_cnt + 1'b1;
                    end
                end
                default:
                begin
                    state <= spipr_pkg::MS_IDLE;
                end
            endcase
        end
    end

    assign serial_shift_clock_oe_o = master_mode_i && !mode_fault_o;
    assign mosi_oe_o = master_mode_i && !mode_fault_o;
    assign mosi_o = m_tx[WORD_BITS-1];

    // ------------------------------------------------------------------
    // slave shifter on the pin clock
    // ------------------------------------------------------------------
    logic samp_clk;
    logic slv_rst;
    logic [CW-1:0] s_cnt;
    logic [CW-1:0] s_lcnt;
    logic [WORD_BITS-1:0] s_rx;
    logic [WORD_BITS-1:0] s_word;
    logic [WORD_BITS-1:0] s_tx;
    logic [WORD_BITS-1:0] tx_hold;
    logic s_bit;

    // polarity and phase fold into which pin edge samples
    assign samp_clk = serial_shift_clock_i ^ (clk_polarity_i ^ clk_phase_i);
    // select high holds the shifter in reset, so the pin clock is ignored
    assign slv_rst = slave_select_n_i || master_mode_i;

    always_ff @(posedge samp_clk or posedge slv_rst)
    begin
        if (slv_rst)
        begin
            s_cnt <= '0;
            s_rx <= '0;
        end
        else
        begin
            s_rx <= shl(s_rx, mosi_i);
            s_cnt <= (s_cnt == LAST_BIT) ? '0 : s_cnt + 1'b1;
        end
    end

    // word and toggle survive the select reset so the core can fetch them
    always_ff @(posedge samp_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_word <= '0;
            word_tgl <= 1'h0;
        end
        else if (!slv_rst && s_cnt == LAST_BIT)
        begin
            s_word <= shl(s_rx, mosi_i);
            word_tgl <= ~word_tgl;
        end
    end

    always_ff @(negedge samp_clk or posedge slv_rst)
    begin
        if (slv_rst)
        begin
            s_lcnt <= '0;
            s_tx <= '0;
        end
        else
        begin
            if (s_lcnt == '0)
            begin
                s_tx <= clk_phase_i ? tx_hold : shl(tx_hold, 1'h0);
            end
            else
            begin
                s_tx <= shl(s_tx, 1'h0);
            end
            s_lcnt <= (s_lcnt == LAST_BIT) ? '0 : s_lcnt + 1'b1;
        end
    end

    // phase 0 shows the first bit as soon as select falls
    assign s_bit = (!clk_phase_i && s_lcnt == '0) ? tx_hold[WORD_BITS-1] : s_tx[WORD_BITS-1];
    assign miso_o = miso_open_drain_enable_i ? 1'h0 : s_bit;
    assign miso_oe_o = !slv_rst && (!miso_open_drain_enable_i || !s_bit);

    // ------------------------------------------------------------------
    // core side of the data path
    // ------------------------------------------------------------------
    logic tgl_seen;

    // tx_hold is read by the pin clock; load it only between frames
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            tx_hold <= '0;
        else if (tx_load_i)
            tx_hold <= tx_data_i;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            tgl_seen <= 1'h0;
            done_o <= 1'h0;
            rx_data_o <= '0;
        end
        else
        begin
            tgl_seen <= word_tgl_s;
            done_o <= 1'h0;
            if (busy_o && !abort && half_end && edge_cnt == LAST_EDGE)
            begin
                done_o <= 1'h1;
                rx_data_o <= clk_phase_i ? shl(m_rx, miso_s) : m_rx;
            end
            else if (word_tgl_s != tgl_seen)
            begin
                done_o <= 1'h1;
                rx_data_o <= s_word;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    mosi_dir_a: assert property (master_mode_i && !mode_fault_o |-> mosi_oe_o)
        else $error("mosi not driven in master role");
    mosi_in_a: assert property (!master_mode_i |-> !mosi_oe_o)
        else $error("mosi driven in slave role");
    miso_od_a: assert property (miso_open_drain_enable_i && miso_oe_o |-> !miso_o)
        else $error("open-drain miso driven high");
    miso_desel_a: assert property (slave_select_n_i |-> !miso_oe_o)
        else $error("deselected slave drives miso");
    miso_master_a: assert property (master_mode_i |-> !miso_oe_o)
        else $error("master drives miso");
    fault_set_a: assert property (master_mode_i && sel_n_s == 1'h0 |=> mode_fault_o)
        else $error("multimaster error not flagged");
    fault_sticky_a: assert property (mode_fault_o && !fault_clear_i |=> mode_fault_o)
        else $error("error flag lost without clear");
    fault_abort_a: assert property (mode_fault_o |=> !busy_o)
        else $error("transfer continues after error");
    sclk_idle_a: assert property (!busy_o ##1 !busy_o |-> serial_shift_clock_o == $past(clk_polarity_i))
        else $error("shift clock not idle between words");
    sclk_hold_a: assert property (busy_o && !abort && half_cnt != LAST_HALF |=> $stable(serial_shift_clock_o))
        else $error("shift clock toggled mid half period");
endmodule : spipr_core

// *** spipr_peer.sv ***
// far-side model: an spi slave for the block in master role, and an spi
// master (80 ns shift clock, also run with select held high) for the block in slave role.
// assumes the bench resolves every shared line with a pull-up.
`timescale 1ns/1ns
// ----
// peer
// ----
module spipr_peer
(
    input wire logic pol_i,
    input wire logic pha_i,
    input wire logic sel_n_i,
    input wire logic [7:0] word_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    output logic mosi_o,
    output logic mosi_oe_o,
    output logic miso_o,
    output logic miso_oe_o,
    output logic dsel_n_o
);
    logic [7:0] sreg;
    logic [7:0] rx;
    logic first;
    int edges;
    initial
    begin
        sclk_o = 1'h1;
        sclk_oe_o = 1'h0;
        mosi_o = 1'h1;
        mosi_oe_o = 1'h0;
        dsel_n_o = 1'h1;
    end
    // driving only while selected keeps a single slave on miso
    assign miso_oe_o = !sel_n_i;
    assign miso_o = sreg[7];
    always @(negedge sel_n_i)
    begin
        sreg = word_i;
        first = 1'h1;
        edges = 0;
    end
    always @(sclk_i)
        if (!sel_n_i)
        begin
            edges++;
            if (sclk_i == (pol_i == pha_i))
                rx = {rx[6:0], mosi_i};
            else if (!first)
                sreg = sreg << 1;
            first = 1'h0;
        end
    task automatic grab(input logic v);
        dsel_n_o = v;
    endtask : grab
    task automatic xfer(input logic [7:0] tx, input logic en);
        int k;
        k = pha_i ? 7 : 6;
        sclk_o = pol_i;
        sclk_oe_o = 1'h1;
        #3;
        dsel_n_o = !en;
        mosi_oe_o = 1'h1;
        mosi_o = tx[7];
        for (int e = 0; e < 16; e++)
        begin
            #40;
            sclk_o = !sclk_o;
            if (e[0] == pha_i)
                rx = {rx[6:0], miso_i};
            else if (k >= 0)
            begin
                mosi_o = tx[k];
                k--;
            end
        end
        #40;
        dsel_n_o = 1'h1;
        mosi_oe_o = 1'h0;
    endtask : xfer
endmodule : spipr_peer

// *** spipr_sync.sv ***
// package of shared constants for the spi pin-role block, plus its
// four-flop input synchroniser.
// assumes a single core clock; the synchroniser input may come from any domain.
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// constants
// ----------------------------------------------------------------------
package spipr_pkg;
    localparam int WORD_BITS = 8;
    localparam int SCLK_HALF_CYCLES = 8;
    localparam logic [0:0] IDLE_HIGH = 1'h1;
    localparam logic [0:0] SEL_ACTIVE = 1'h0;
    typedef enum logic [0:0] {MS_IDLE, MS_SHIFT} spipr_mst_e;
endpackage : spipr_pkg

// ----------------------------------------------------------------------
// synchroniser
// ----------------------------------------------------------------------
module spipr_sync
#(
    parameter logic INIT = 1'h1
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);
    logic ff1;
    logic ff2;
    logic ff3;

    // first flop feeds only the second; a change counts once ff2 and ff3 agree
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            ff1 <= INIT;
            ff2 <= INIT;
            ff3 <= INIT;
            sync_o <= INIT;
        end
        else
        begin
            ff1 <= async_i;
            ff2 <= ff1;
            ff3 <= ff2;
            if (ff2 == ff3)
            begin
                sync_o <= ff3;
            end
        end
    end
endmodule : spipr_sync
